// ---- dv/apd_src_model.sv ----
// apd_src_model: audio source on the far side of the serial audio link.
// assumes send_frame is called only while the link is idle; the bit clock
// stands still between frames and rests at the level set by the invert bit.
`default_nettype none
module apd_src_model (
    output logic link_bclk,
    output logic frame_sync,
    output logic [2:0] serial_in_lines
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        link_bclk = 1'b0;
        frame_sync = 1'b0;
        serial_in_lines = 3'h0;
    end

    // lines change on the launch edge, the sampling edge comes half a period later
    task automatic put_bit(input logic s, input logic [2:0] d);
        frame_sync = s;
        serial_in_lines = d;
        #32 link_bclk = ~link_bclk;
        #32 link_bclk = ~link_bclk;
    endtask : put_bit

    task automatic send_frame(input logic [1:0] fmt, input logic pol, input logic inv,
                              input logic [1:0] wl, input logic [5:0][31:0] w);
        int n;
        int pos;
        int off;
        logic lvl;
        logic s;
        logic [2:0] d;
        n = (wl == 2'h3) ? 32 : 16 + 4 * int'(wl);
        off = (fmt == 2'h2) ? 1 : (fmt == 2'h1) ? 0 : 32 - n;
        lvl = (fmt != 2'h2) ^ pol;
        link_bclk = inv;
        for (int b = -4; b < ((fmt == 2'h3) ? 6 * n : 64) + 2; b++) begin
            // idle and unused bits toggle so a stale value never looks valid
            d = ~serial_in_lines;
            if (fmt == 2'h3) begin
                s = pol ? (b == 0) : (b == -1);
                if (b >= 0 && b < 6 * n) begin
                    d[0] = w[b / n][n - 1 - b % n];
                end
            end else begin
                // 32-bit halves keep the sync level of each half 32 clocks long
                pos = (b < 0) ? 99 : b % 32;
                s = ((b >= 0 && b < 32) || b >= 64) ? lvl : ~lvl;
                if (b < 64 && pos >= off && pos - off < n) begin
                    for (int p = 0; p < 3; p++) begin
                        d[p] = w[2 * p + b / 32][n - 1 - (pos - off)];
                    end
                end
            end
            put_bit(s, d);
        end
        serial_in_lines = ~serial_in_lines;
    endtask : send_frame
endmodule : apd_src_model
`default_nettype wire

// ---- dv/tb_audio_port_dac_channel_control.sv ----
// tb_audio_port_dac_channel_control: self-checking bench for apd_top.
// assumes apd_src_model drives the audio link and registers go over the control pins.
`default_nettype none
module tb_audio_port_dac_channel_control;
    timeunit 1ns;
    timeprecision 100ps;
    import apd_pkg::*;

    // {format, polarity, word length}; 32-bit right justified is never chosen
    localparam logic [4:0] FT [10] = '{5'h0b, 5'h12, 5'h01, 5'h18, 5'h1e,
                                       5'h0c, 5'h15, 5'h09, 5'h02, 5'h1b};
    logic clk_sys, arst_n, ctl_data, ctl_clk, ctl_latch;
    logic link_bclk, frame_sync, dac_valid, silence_flag_pin, pl, iv, watch;
    logic [2:0] serial_in_lines, ph;
    logic [5:0] vol_update_req, vol_apply, seen;
    logic [5:0][FILT_W-1:0] dac_words, got;
    logic [5:0][31:0] w;
    logic [3:0] rt;
    logic [1:0] fm, wl;
    int err_total, n_tests, vnum, cyc;

    apd_top i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .ctl_data(ctl_data),
        .ctl_clk(ctl_clk), .ctl_latch(ctl_latch), .link_bclk(link_bclk),
        .frame_sync(frame_sync), .serial_in_lines(serial_in_lines),
        .vol_update_req(vol_update_req), .vol_apply(vol_apply), .dac_words(dac_words),
        .dac_valid(dac_valid), .silence_flag_pin(silence_flag_pin));
    apd_src_model i_src (.link_bclk(link_bclk), .frame_sync(frame_sync),
        .serial_in_lines(serial_in_lines));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        seen <= watch ? (seen | vol_apply) : 6'h00;
        if (dac_valid === 1'b1) begin
            got <= dac_words;
            vnum <= vnum + 1;
        end
        if (cyc == 90000) begin
            err_total = err_total + 1;
            end_of_test();
        end
    end

    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic ctl_write(input logic [6:0] a, input logic [8:0] v);
        logic [15:0] wd;
        wd = {a, v};
        for (int i = 15; i >= 0; i--) begin
            ctl_data = wd[i];
            tick(4);
            ctl_clk = 1'b1;
            tick(4);
            ctl_clk = 1'b0;
        end
        tick(4);
        ctl_latch = 1'b1;
        tick(4);
        ctl_latch = 1'b0;
        tick(8);
    endtask : ctl_write

    task automatic cfg(input logic [1:0] f, input logic p, input logic i, input logic [1:0] l);
        fm = f;
        pl = p;
        iv = i;
        wl = l;
        ctl_write(ROUTE_ADDR, {rt, 5'h00});
        ctl_write(FMT_ADDR, {ph, wl, iv, pl, fm});
    endtask : cfg

    function automatic logic [23:0] algn(input logic [31:0] x);
        case (wl)
            2'h0: return {x[15:0], 8'h00};
            2'h1: return {x[19:0], 4'h0};
            2'h2: return x[23:0];
            default: return x[31:8];
        endcase
    endfunction : algn

    function automatic logic [23:0] expw(input int k);
        logic [24:0] sum;
        logic [23:0] l, r, v;
        logic [1:0] s;
        l = algn(w[k & 6]);
        r = algn(w[k | 1]);
        sum = {l[23], l} + {r[23], r};
        s = (k % 2) ? rt[3:2] : rt[1:0];
        case (s)
            2'h0: v = 24'h000000;
            2'h1: v = l;
            2'h2: v = r;
            default: v = sum[24:1];
        endcase
        if (ph[k / 2] && v != 24'h800000) begin
            v = -v;
        end
        return v;
    endfunction : expw

    task automatic fill(input int sd);
        for (int k = 0; k < 6; k++) begin
            w[k] = 32'h9e3779b9 * (sd * 6 + k + 1);
        end
    endtask : fill

    // one frame, then exactly one new set of filter words
    task automatic frame(input string nm);
        int n0;
        n0 = vnum;
        i_src.send_frame(fm, pl, iv, wl, w);
        for (int t = 0; t < 60 && vnum == n0; t++) begin
            tick(1);
        end
        chk(vnum - n0, 1);
        for (int k = 0; k < 6; k++) begin
            chk(got[k], expw(k));
        end
        $display("test %s done", nm);
    endtask : frame

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        {arst_n, ctl_data, ctl_clk, ctl_latch, pl, iv} = 6'h00;
        vol_update_req = 6'h00;
        watch = 1'b0;
        rt = 4'h9;
        ph = 3'h0;
        fm = 2'h0;
        wl = 2'h0;
        tick(6);
        arst_n = 1'b1;
        tick(2);
        chk({dac_valid, silence_flag_pin, vol_apply}, 32'h0);
        fill(1);
        frame("reset_defaults");
        for (int i = 0; i < 10; i++) begin
            cfg(FT[i][4:3], FT[i][2], 1'b0, FT[i][1:0]);
            fill(i + 2);
            frame("format");
        end
        for (int r = 0; r < 16; r++) begin
            rt = 4'(r);
            ph = rt[2:0];
            cfg(2'h1, 1'b0, 1'b0, 2'h2);
            fill(r + 20);
            if (r == 1) begin
                w[0] = 32'h00800000;
            end
            frame("route_phase");
        end
        rt = 4'h9;
        ph = 3'h0;
        cfg(2'h2, 1'b0, 1'b1, 2'h1);
        fill(40);
        frame("clock_invert");
        cfg(2'h2, 1'b0, 1'b0, 2'h1);
        ctl_write(ZC_ADDR, 9'h001);
        for (int i = 0; i < 6; i++) begin
            vol_update_req = 6'h01 << i;
            tick(1);
            vol_update_req = 6'h00;
            chk(vol_apply, 6'h01 << i);
        end
        ctl_write(ZC_ADDR, 9'h000);
        w = {6{32'h00001234}};
        frame("vol_reference");
        vol_update_req = 6'h3f;
        tick(1);
        vol_update_req = 6'h00;
        // apply pulses count only from here on
        watch = 1'b1;
        frame("vol_same_sign");
        chk(seen, 6'h00);
        w = '0;
        frame("vol_zero");
        tick(4);
        chk(seen, 6'h3f);
        chk(silence_flag_pin, 1'b0);
        end_of_test();
    end
endmodule : tb_audio_port_dac_channel_control
`default_nettype wire

// ---- logic/apd_ctl_port.sv ----
// apd_ctl_port: three-wire serial control port, 16-bit write words.
// assumes the pins are asynchronous to clk_sys and far slower than it.
`default_nettype none
module apd_ctl_port (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ctl_data,
    input wire logic ctl_clk,
    input wire logic ctl_latch,
    output logic wr_pulse,
    output logic [6:0] wr_addr,
    output logic [8:0] wr_data
);
    import apd_pkg::*;

    typedef struct packed {
        logic [1:0] d_s;
        logic [2:0] c_s;
        logic [2:0] l_s;
        logic [15:0] sh;
        logic wr;
        logic [6:0] addr;
        logic [8:0] data;
    } apd_ctl_t;

    apd_ctl_t s_q;
    apd_ctl_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.d_s = {s_q.d_s[0], ctl_data};
        s_d.c_s = {s_q.c_s[1:0], ctl_clk};
        s_d.l_s = {s_q.l_s[1:0], ctl_latch};
        s_d.wr = 1'b0;
        // data and clock share the same sync depth, so they stay aligned
        if (s_q.c_s[1] && !s_q.c_s[2]) begin
            s_d.sh = {s_q.sh[14:0], s_q.d_s[1]};
        end
        if (s_q.l_s[1] && !s_q.l_s[2]) begin
            s_d.wr = 1'b1;
            s_d.addr = s_q.sh[15:9];
            s_d.data = s_q.sh[8:0];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign wr_pulse = s_q.wr;
    assign wr_addr = s_q.addr;
    assign wr_data = s_q.data;
endmodule : apd_ctl_port
`default_nettype wire

// ---- logic/apd_link_rx.sv ----
// apd_link_rx: serial audio receiver on the bit clock, six words a frame.
// assumes the config inputs are quasi-static levels from clk_sys.
`default_nettype none
module apd_link_rx (
    input wire logic link_clk,
    input wire logic arst_n,
    input wire logic frame_sync,
    input wire logic [2:0] serial_in_lines,
    input wire logic [1:0] fmt,
    input wire logic pol,
    input wire logic [1:0] wl,
    output logic [5:0][apd_pkg::FILT_W-1:0] words,
    output logic done_tog
);
    import apd_pkg::*;

    typedef struct packed {
        logic [4:0] cfg_a;
        logic [4:0] cfg_b;
        logic fs_prev;
        logic [2:0][31:0] sh;
        logic [5:0] pos;
        logic [2:0] slot;
        logic act;
        logic [5:0][FILT_W-1:0] words;
        logic tog;
    } apd_rx_t;

    apd_rx_t s_q;
    apd_rx_t s_d;
    logic [1:0] c_fmt;
    logic c_pol;
    logic [1:0] c_wl;
    logic [5:0] nbits;
    logic left_lvl;
    logic cap;
    logic right;
    logic [2:0][31:0] src;

    assign c_fmt = s_q.cfg_b[4:3];
    assign c_pol = s_q.cfg_b[2];
    assign c_wl = s_q.cfg_b[1:0];
    assign nbits = wl_bits(c_wl);
    // i2s puts left on low sync; the polarity bit flips either layout
    assign left_lvl = ~((c_fmt == FMT_I2S) ^ c_pol);

    always_comb begin
        s_d = s_q;
        cap = 1'b0;
        right = 1'b0;
        src = s_q.sh;
        s_d.cfg_a = {fmt, pol, wl};
        s_d.cfg_b = s_q.cfg_a;
        s_d.fs_prev = frame_sync;
        for (int i = 0; i < 3; i++) begin
            s_d.sh[i] = {s_q.sh[i][30:0], serial_in_lines[i]};
        end
        if (c_fmt == FMT_DSP) begin
            if (frame_sync && !s_q.fs_prev) begin
                s_d.act = 1'b1;
                s_d.slot = 3'h0;
                s_d.pos = c_pol ? 6'h01 : 6'h00;
            end else if (s_q.act) begin
                s_d.pos = s_q.pos + 6'h01;
            end
            if (s_d.act && s_d.pos == nbits) begin
                s_d.words[s_d.slot] = align_word(s_d.sh[0], c_wl);
                s_d.pos = 6'h00;
                if (s_d.slot == LAST_SLOT) begin
                    s_d.act = 1'b0;
                    s_d.tog = ~s_q.tog;
                end
                s_d.slot = s_d.slot + 3'h1;
            end
        end else begin
            // a dsp frame cut short must not leave a running word count behind
            s_d.act = 1'b0;
            if (frame_sync != s_q.fs_prev) begin
                s_d.pos = 6'h01;
                // right justified words end on the bit before the sync edge; a half
                // shorter than one word is idle time after reset, not a sample
                cap = c_fmt == FMT_RJ && s_q.pos >= nbits;
                right = s_q.fs_prev != left_lvl;
            end else begin
                if (s_q.pos != 6'h3f) begin
                    s_d.pos = s_q.pos + 6'h01;
                end
                cap = c_fmt != FMT_RJ &&
                      s_d.pos == ((c_fmt == FMT_I2S) ? nbits + 6'h01 : nbits);
                right = frame_sync != left_lvl;
                src = s_d.sh;
            end
        end
        if (cap) begin
            for (int i = 0; i < 3; i++) begin
                s_d.words[2 * i + int'(right)] = align_word(src[i], c_wl);
            end
            // frames close on the right word, so a swapped pair lags a sample
            if (right) begin
                s_d.tog = ~s_q.tog;
            end
        end
    end

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign words = s_q.words;
    assign done_tog = s_q.tog;
endmodule : apd_link_rx
`default_nettype wire

// ---- logic/apd_pkg.sv ----
// apd_pkg: register map, field layout, reset values and helpers of the
// audio port dac channel control block.
// assumes the 9-bit register data and 7-bit addresses of the control port.
`default_nettype none
package apd_pkg;
    localparam int FILT_W = 24;
    localparam logic [6:0] ROUTE_ADDR = 7'h02;
    localparam logic [6:0] FMT_ADDR = 7'h03;
    localparam logic [6:0] ZC_ADDR = 7'h09;
    localparam int ROUTE_LSB = 5;
    localparam int FMT_LSB = 0;
    localparam int POL_BIT = 2;
    localparam int INV_BIT = 3;
    localparam int WL_LSB = 4;
    localparam int PHASE_LSB = 6;
    localparam int ZCD_BIT = 0;
    localparam int FSEL_LSB = 1;
    localparam logic [3:0] ROUTE_RST = 4'h9;
    localparam logic [1:0] FMT_RST = 2'h0;
    localparam logic [1:0] WL_RST = 2'h0;
    localparam logic [2:0] PHASE_RST = 3'h0;
    localparam logic [1:0] FSEL_RST = 2'h0;
    localparam logic ZCD_RST = 1'h0;
    localparam logic [10:0] ZERO_RUN = 11'h400;
    localparam logic [1:0] FMT_RJ = 2'h0;
    localparam logic [1:0] FMT_LJ = 2'h1;
    localparam logic [1:0] FMT_I2S = 2'h2;
    localparam logic [1:0] FMT_DSP = 2'h3;
    localparam logic [1:0] WL_16 = 2'h0;
    localparam logic [1:0] WL_20 = 2'h1;
    localparam logic [1:0] WL_24 = 2'h2;
    localparam logic [2:0] LAST_SLOT = 3'h5;

    function automatic logic [5:0] wl_bits(input logic [1:0] wl);
        case (wl)
            WL_16: return 6'h10;
            WL_20: return 6'h14;
            WL_24: return 6'h18;
            default: return 6'h20;
        endcase
    endfunction : wl_bits

    // signed samples: short words are padded at the bottom, long ones cut
    function automatic logic [FILT_W-1:0] align_word(input logic [31:0] sh,
                                                     input logic [1:0] wl);
        case (wl)
            WL_16: return {sh[15:0], 8'h00};
            WL_20: return {sh[19:0], 4'h0};
            WL_24: return sh[23:0];
            default: return sh[31:8];
        endcase
    endfunction : align_word
endpackage : apd_pkg
`default_nettype wire

// ---- logic/apd_top.sv ----
// apd_top: audio port dac channel control, registers, routing, inversion,
// zero-cross gated volume update and the silence flag.
// assumes link_bclk comes from the audio source and is unrelated to clk_sys;
// vol_update_req comes from volume logic on clk_sys.
`default_nettype none
module apd_top (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ctl_data,
    input wire logic ctl_clk,
    input wire logic ctl_latch,
    input wire logic link_bclk,
    input wire logic frame_sync,
    input wire logic [2:0] serial_in_lines,
    input wire logic [5:0] vol_update_req,
    output logic [5:0] vol_apply,
    output logic [5:0][apd_pkg::FILT_W-1:0] dac_words,
    output logic dac_valid,
    output logic silence_flag_pin
);
    import apd_pkg::*;

    typedef struct packed {
        logic [3:0] route;
        logic [1:0] fmt;
        logic pol;
        logic inv;
        logic [1:0] wl;
        logic [2:0] phase;
        logic cross_detect_off;
        logic [1:0] fsel;
        logic tg_a;
        logic tg_b;
        logic tg_c;
        logic [5:0][FILT_W-1:0] in_w;
        logic newf;
        logic [5:0][FILT_W-1:0] out_w;
        logic valid;
        logic [5:0][10:0] zc;
        logic [5:0] pend;
        logic [5:0] apply;
        logic flag;
    } apd_top_t;

    apd_top_t s_q;
    apd_top_t s_d;
    logic wr_pulse;
    logic [6:0] wr_addr;
    logic [8:0] wr_data;
    logic link_clk;
    logic link_tog;
    logic [5:0][FILT_W-1:0] link_words;
    logic frame_new;
    logic [5:0] zero;
    logic [FILT_W-1:0] in_l0;
    logic [FILT_W-1:0] link_w0;
    logic [FILT_W-1:0] in_r0;

    function automatic logic [FILT_W-1:0] route_pick(input logic [1:0] code,
                                                     input logic [FILT_W-1:0] l,
                                                     input logic [FILT_W-1:0] r);
        logic [FILT_W:0] sum;
        sum = {l[FILT_W-1], l} + {r[FILT_W-1], r};
        case (code)
            2'h0: return '0;
            2'h1: return l;
            2'h2: return r;
            default: return sum[FILT_W:1];
        endcase
    endfunction : route_pick

    // negation of full-scale negative wraps to itself; accepted, one code
    function automatic logic [FILT_W-1:0] negate(input logic [FILT_W-1:0] x);
        return ~x + 1'b1;
    endfunction : negate

    apd_ctl_port u_ctl (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .ctl_data(ctl_data),
        .ctl_clk(ctl_clk),
        .ctl_latch(ctl_latch),
        .wr_pulse(wr_pulse),
        .wr_addr(wr_addr),
        .wr_data(wr_data)
    );

    // the invert bit is static while audio runs; changing it mid-frame
    // gives one clipped bit clock, so reprogram only with the link idle
    assign link_clk = link_bclk ^ s_q.inv;

    apd_link_rx u_rx (
        .link_clk(link_clk),
        .arst_n(arst_n),
        .frame_sync(frame_sync),
        .serial_in_lines(serial_in_lines),
        .fmt(s_q.fmt),
        .pol(s_q.pol),
        .wl(s_q.wl),
        .words(link_words),
        .done_tog(link_tog)
    );

    // words are stable for a whole half-frame after the toggle moves
    assign frame_new = s_q.tg_b != s_q.tg_c;
    assign in_l0 = s_q.in_w[0];
    assign in_r0 = s_q.in_w[1];
    assign link_w0 = link_words[0];

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            zero[i] = s_q.zc[i] == ZERO_RUN;
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.tg_a = link_tog;
        s_d.tg_b = s_q.tg_a;
        s_d.tg_c = s_q.tg_b;
        s_d.valid = 1'b0;
        s_d.newf = frame_new;
        s_d.apply = '0;
        if (wr_pulse) begin
            case (wr_addr)
                ROUTE_ADDR: begin
                    s_d.route = wr_data[ROUTE_LSB +: 4];
                end
                FMT_ADDR: begin
                    s_d.fmt = wr_data[FMT_LSB +: 2];
                    s_d.pol = wr_data[POL_BIT];
                    s_d.inv = wr_data[INV_BIT];
                    s_d.wl = wr_data[WL_LSB +: 2];
                    s_d.phase = wr_data[PHASE_LSB +: 3];
                end
                ZC_ADDR: begin
                    s_d.cross_detect_off = wr_data[ZCD_BIT];
                    s_d.fsel = wr_data[FSEL_LSB +: 2];
                end
                default: begin
                end
            endcase
        end
        for (int i = 0; i < 6; i++) begin
            if (frame_new) begin
                s_d.in_w[i] = link_words[i];
                if (link_words[i] == '0) begin
                    if (s_q.zc[i] != ZERO_RUN) begin
                        s_d.zc[i] = s_q.zc[i] + 11'h001;
                    end
                end else begin
                    s_d.zc[i] = '0;
                end
            end
            // a request waits for the sample sign to change or hit zero
            if ((s_q.pend[i] || vol_update_req[i]) &&
                (s_q.cross_detect_off || (frame_new &&
                 (link_words[i] == '0 ||
                  link_words[i][FILT_W-1] != s_q.in_w[i][FILT_W-1])))) begin
                s_d.apply[i] = 1'b1;
                s_d.pend[i] = 1'b0;
            end else if (vol_update_req[i]) begin
                s_d.pend[i] = 1'b1;
            end
        end
        if (s_q.newf) begin
            s_d.valid = 1'b1;
            for (int p = 0; p < 3; p++) begin
                s_d.out_w[2 * p] = route_pick(s_q.route[1:0],
                                              s_q.in_w[2 * p],
                                              s_q.in_w[2 * p + 1]);
                s_d.out_w[2 * p + 1] = route_pick(s_q.route[3:2],
                                                  s_q.in_w[2 * p],
                                                  s_q.in_w[2 * p + 1]);
                if (s_q.phase[p]) begin
                    s_d.out_w[2 * p] = negate(s_d.out_w[2 * p]);
                    s_d.out_w[2 * p + 1] = negate(s_d.out_w[2 * p + 1]);
                end
            end
        end
        case (s_q.fsel)
            2'h0: s_d.flag = &zero;
            2'h1: s_d.flag = &zero[1:0];
            2'h2: s_d.flag = &zero[3:2];
            default: s_d.flag = &zero[5:4];
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.route <= ROUTE_RST;
            s_q.fmt <= FMT_RST;
            s_q.wl <= WL_RST;
            s_q.phase <= PHASE_RST;
            s_q.cross_detect_off <= ZCD_RST;
            s_q.fsel <= FSEL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign vol_apply = s_q.apply;
    assign dac_words = s_q.out_w;
    assign dac_valid = s_q.valid;
    assign silence_flag_pin = s_q.flag;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    chk_route_load: assert property (
        wr_pulse && wr_addr == ROUTE_ADDR && wr_data[8:5] == 4'h3
        |=> s_q.route == 4'h3)
        else $error("route field not loaded from control word");

    chk_fmt_load: assert property (
        wr_pulse && wr_addr == FMT_ADDR && wr_data[1:0] == FMT_DSP
        |=> s_q.fmt == FMT_DSP && $stable(s_q.route))
        else $error("format field not loaded");

    chk_pass_left: assert property (
        s_q.newf && s_q.route == 4'h9 && !s_q.phase[0]
        |=> dac_valid && dac_words[0] == $past(in_l0))
        else $error("left input not passed to pair 1 left");

    chk_invert_pair: assert property (
        s_q.newf && s_q.route == 4'h9 && s_q.phase[0]
        |=> dac_words[0] == ~$past(in_l0) + 1'b1)
        else $error("pair 1 output not negated");

    chk_mute_route: assert property (
        s_q.newf && s_q.route[1:0] == 2'h0 |=> dac_words[0] == '0)
        else $error("muted route carries data");

    chk_zero_clear: assert property (
        frame_new && link_w0 != '0 |=> s_q.zc[0] == 11'h000 ##1 !zero[0])
        else $error("zero counter not restarted");

    chk_flag_pair: assert property (
        s_q.fsel == 2'h1 && zero[0] && zero[1] |=> silence_flag_pin)
        else $error("silence flag missing for pair 1");

    chk_zcd_off: assert property (
        s_q.cross_detect_off && vol_update_req[0] |=> vol_apply[0])
        else $error("volume not applied at once with detect off");

    chk_zc_wait: assert property (
        !s_q.cross_detect_off && vol_update_req[0] && !frame_new && !s_q.pend[0]
        |=> !vol_apply[0] ##0 s_q.pend[0])
        else $error("volume applied without a zero crossing");

    chk_right_pass: assert property (
        s_q.newf && s_q.route == 4'h9 && !s_q.phase[0]
        |=> dac_words[1] == $past(in_r0))
        else $error("right input not passed to pair 1 right");

    chk_valid_once: assert property (
        dac_valid |=> !dac_valid)
        else $error("filter words presented twice for one frame");

    chk_flag_all: assert property (
        s_q.fsel == 2'h0 && !zero[0] |=> !silence_flag_pin)
        else $error("silence flag set with a live channel");

    chk_zero_count: assert property (
        frame_new && link_w0 == '0 && !zero[0]
        |=> s_q.zc[0] == $past(s_q.zc[0]) + 11'h001)
        else $error("zero sample not counted");

    chk_zc_apply: assert property (
        !s_q.cross_detect_off && s_q.pend[0] && frame_new && link_w0 == '0 |=> vol_apply[0])
        else $error("pending volume not applied at zero sample");

    chk_zc_hold: assert property (
        !s_q.cross_detect_off && s_q.pend[0] && !frame_new && !vol_update_req[0]
        |=> !vol_apply[0] && s_q.pend[0])
        else $error("pending volume applied between samples");

    chk_phase_load: assert property (
        wr_pulse && wr_addr == FMT_ADDR && wr_data[8:6] == 3'h5 |=> s_q.phase == 3'h5)
        else $error("phase field not loaded");

    chk_inv_load: assert property (
        wr_pulse && wr_addr == FMT_ADDR && wr_data[3] |=> s_q.inv)
        else $error("clock invert bit not loaded");

    chk_zcd_load: assert property (
        wr_pulse && wr_addr == ZC_ADDR && wr_data[0] |=> s_q.cross_detect_off)
        else $error("cross detect off bit not loaded");
endmodule : apd_top
`default_nettype wire
